/* bench/pct_trig_sink.sv */
`timescale 1ns/1ns
// ********
// trigger receiver: counts pulses, times the last one
// ********
module pct_trig_sink
(
	input wire logic clk,
	input wire logic clr,
	input wire logic trig,
	output logic [7:0] n_pulse,
	output logic [15:0] last_len
);
	logic [15:0] run_q;
	// count rising edges and high cycles
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			n_pulse <= 8'h00;
			run_q <= 16'h0000;
		end
		else if (trig)
		begin
			run_q <= run_q + 16'h0001;
			if (run_q == 16'h0000)
				n_pulse <= n_pulse + 8'h01;
		end
		else if (run_q != 16'h0000)
		begin
			last_len <= run_q; // latched on fall
			run_q <= 16'h0000;
		end
	end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top
	import pct_pkg::*;
;
	localparam int T = 10;
	logic clk, rst, psel, penable, pwrite, position_strobe, clr, pready, pslverr, err, t1, t2, t3, cfe, rsb, en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, actual_position, rd, d;
	logic [3:0] st;
	logic [15:0] e2;
	logic [7:0] pc[3];
	logic [15:0] pl[3];
	int n_mismatch = 0;
	int num_checks = 0;
	int seed = 98626;
	int wd;
	// ********
	// design and receivers
	// ********
	pct_top #(.TICK_CYCLES(T)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.actual_position(actual_position), .position_strobe(position_strobe), .motion_in_progress(st[0]),
		.mains_off_flag(st[1]), .retract_status(st[2]), .virtual_loop_or_feedback_status(st[3]),
		.trigger_terminal_one(t1), .trigger_terminal_two(t2), .trigger_terminal_three(t3),
		.compare_function_enabled_status(cfe), .response_status_bit(rsb));
	pct_trig_sink s1 (.clk(clk), .clr(clr), .trig(t1), .n_pulse(pc[0]), .last_len(pl[0]));
	pct_trig_sink s2 (.clk(clk), .clr(clr), .trig(t2), .n_pulse(pc[1]), .last_len(pl[1]));
	pct_trig_sink s3 (.clk(clk), .clr(clr), .trig(t3), .n_pulse(pc[2]), .last_len(pl[2]));
	// 50 MHz clock
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// ********
	// tasks and expectations
	// ********
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task close_out;
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one apb transfer, held until pready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dv;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task strobe(input logic [31:0] p);
		@(posedge clk);
		actual_position <= p;
		position_strobe <= 1'h1;
		@(posedge clk);
		position_strobe <= 1'h0;
	endtask
	task settle;
		repeat (wd * T + 8) @(posedge clk);
	endtask
	task clr_cnt;
		@(posedge clk);
		clr <= 1'h1;
		@(posedge clk);
		clr <= 1'h0;
	endtask
	task pulses(input int a, input int b, input int c, input int len);
		int e[3];
		e = '{a, b, c};
		for (int i = 0; i < 3; i++)
		begin
			chk("pulse count", e[i], pc[i]);
			if (e[i] > 0)
				chk("pulse length", len, pl[i]);
		end
	endtask
	function logic exp_status(input logic [15:0] x, input logic [1:0] fs, input logic [3:0] s, input logic on);
		if (!x[15])
			return x[8] ? s[1] : s[0];
		case (fs)
			2'h0: return s[2];
			2'h1: return s[3];
			2'h2: return on;
			default: return 1'h0;
		endcase
	endfunction
	function logic [31:0] rmask(input logic [7:0] a);
		return (a == PCT_OFF_DELAY || a >= PCT_OFF_EXP2) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
	endfunction
	// watchdog
	initial
	begin
		#400000;
		n_mismatch++;
		close_out;
	end
	// ********
	// main sequence
	// ********
	initial
	begin
		rst = 1'h1;
		clr = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		actual_position = 32'h0;
		position_strobe = 1'h0;
		st = 4'h0;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		clr <= 1'h0;
		// reset values, then refused places
		for (int a = 0; a < 60; a += 4)
		begin
			apb(1'h0, a[7:0], 32'h0);
			chk("reset value", a >= 52, rd);
			chk("read error", 0, err);
		end
		apb(1'h1, PCT_OFF_STATE, 32'hFFFF_FFFF);
		apb(1'h0, PCT_OFF_STATE, 32'h0);
		chk("state after write", 1, rd);
		for (int i = 0; i < 2; i++)
		begin
			apb(1'h0, i ? 8'h02 : 8'h3C, 32'h0);
			chk("unmapped error", 1, err);
			chk("unmapped data", 0, rd);
		end
		// random write and readback
		for (int a = 0; a < 56; a += 4)
		begin
			d = $random(seed);
			if (a == 36)
				d &= 32'h3333_3333;
			apb(1'h1, a[7:0], d);
			apb(1'h0, a[7:0], 32'h0);
			chk("readback", d & rmask(a[7:0]), rd);
		end
		wd = 1 + {$random(seed)} % 3;
		apb(1'h1, PCT_OFF_WIDTH, wd);
		apb(1'h1, PCT_OFF_EXP3, 32'h0);
		apb(1'h1, PCT_OFF_DELAY, 32'h0);
		for (int k = 1; k <= 8; k++)
			apb(1'h1, 8'(4 * k - 4), 1000 * k);
		// each nibble and code, both directions
		for (int c = 0; c < 4; c++)
			for (int n = 1; n <= 8; n++)
			begin
				apb(1'h1, PCT_OFF_ROUTE, 32'h0);
				strobe(1000 * n - 5);
				settle;
				clr_cnt;
				apb(1'h1, PCT_OFF_ROUTE, c << (4 * n - 4));
				strobe(1000 * n + 5);
				settle;
				strobe(1000 * n - 5);
				settle;
				pulses(c == 1 ? 2 : 0, c == 2 ? 2 : 0, c == 3 ? 2 : 0, wd * T);
			end
		// shared terminal
		apb(1'h1, PCT_OFF_ROUTE, 32'h11);
		strobe(500);
		settle;
		clr_cnt;
		strobe(1500);
		settle;
		strobe(2500);
		settle;
		pulses(2, 0, 0, wd * T);
		// crossing back during a pulse
		apb(1'h1, PCT_OFF_ROUTE, 32'h1);
		strobe(995);
		settle;
		clr_cnt;
		strobe(1005);
		repeat (4) @(posedge clk);
		strobe(995);
		settle;
		pulses(1, 0, 0, wd * T + 6);
		// resting on the value
		clr_cnt;
		repeat (3)
		begin
			strobe(1000);
			settle;
		end
		strobe(1005);
		settle;
		pulses(1, 0, 0, wd * T);
		// speed-based advance of the compared position
		apb(1'h1, PCT_OFF_DELAY, 625);
		strobe(880);
		strobe(900);
		settle;
		clr_cnt;
		strobe(960);
		settle;
		pulses(1, 0, 0, wd * T);
		apb(1'h1, PCT_OFF_DELAY, 32'h0);
		strobe(960);
		settle;
		// disabled function
		clr_cnt;
		apb(1'h1, PCT_OFF_EXP3, 32'h400);
		@(posedge clk);
		chk("enabled status", 0, cfe);
		strobe(1005);
		settle;
		pulses(0, 0, 0, 0);
		apb(1'h1, PCT_OFF_EXP3, 32'h0);
		@(posedge clk);
		chk("enabled status", 1, cfe);
		strobe(995);
		repeat (5) @(posedge clk);
		apb(1'h1, PCT_OFF_EXP3, 32'h400);
		repeat (2) @(posedge clk);
		chk("terminal dropped", 0, t1);
		// status source selection
		for (int k = 0; k < 16; k++)
		begin
			e2 = {k[3], 6'h00, k[2], 8'h00};
			en = 1'($random(seed));
			apb(1'h1, PCT_OFF_EXP2, {16'h0000, e2});
			apb(1'h1, PCT_OFF_FLAGSEL, {30'h0, k[1:0]});
			apb(1'h1, PCT_OFF_EXP3, {21'h0, ~en, 10'h0});
			@(posedge clk);
			st <= 4'($random(seed));
			repeat (2) @(posedge clk);
			chk("status bit", exp_status(e2, k[1:0], st, en), rsb);
		end
		close_out;
	end
endmodule

/* src/pct_cross_det.sv */
`timescale 1ns/1ns
module pct_cross_det
	import pct_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sample,
	input wire logic [31:0] position,
	input wire logic [31:0] value,
	output logic hit
);
	typedef struct packed {
		logic seen;
		logic side_gt;
		logic at_eq;
		logic hit;
	} pct_cross_state_t;
	pct_cross_state_t q, d;
	logic eq, gt;

	// ************************************************************
	// relation tracking
	// ************************************************************
	assign eq = position == value;
	assign gt = $signed(position) > $signed(value);
	always_comb
	begin
		d = q;
		d.hit = 1'b0;
		if (sample)
		begin
			d.seen = 1'b1;
			if (eq)
			begin
				d.hit = q.seen && !q.at_eq;
				d.at_eq = 1'b1;
			end
			else
			begin
				d.hit = q.seen && !q.at_eq && (gt != q.side_gt);
				d.side_gt = gt;
				d.at_eq = 1'b0;
			end
		end
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end
	assign hit = q.hit;

	property p_cross;
		@(posedge clk) disable iff (rst)
		sample && q.seen && !q.at_eq && !eq && (gt != q.side_gt) |=> hit;
	endproperty
	a_cross: assert property (p_cross) else $error("missed crossing");
	property p_rest;
		@(posedge clk) disable iff (rst)
		sample && q.at_eq && eq |=> !hit;
	endproperty
	a_rest: assert property (p_rest) else $error("repeat pulse at rest");
endmodule

/* src/pct_pkg.sv */
package pct_pkg;
	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0] PCT_OFF_CMP_BASE = 8'h00; // compare value n at base + 4*(n-1)
	localparam logic [7:0] PCT_OFF_DELAY = 8'h20;
	localparam logic [7:0] PCT_OFF_ROUTE = 8'h24;
	localparam logic [7:0] PCT_OFF_EXP3 = 8'h28;
	localparam logic [7:0] PCT_OFF_EXP2 = 8'h2C;
	localparam logic [7:0] PCT_OFF_FLAGSEL = 8'h30;
	localparam logic [7:0] PCT_OFF_WIDTH = 8'h34;
	localparam logic [7:0] PCT_OFF_STATE = 8'h38;
	// ************************************************************
	// sizes and field positions
	// ************************************************************
	localparam int PCT_N_CMP = 8;
	localparam int PCT_N_TERM = 3;
	localparam int PCT_ROUTE_W = 4;
	localparam int PCT_EXP3_DISABLE_BIT = 10;
	localparam int PCT_EXP2_ACOFF_BIT = 8;
	localparam int PCT_EXP2_EXPAND_BIT = 15;
	localparam logic [3:0] PCT_ROUTE_NONE = 4'h0;
	localparam logic [15:0] PCT_SEL_RETRACT = 16'h0000;
	localparam logic [15:0] PCT_SEL_VLOOP = 16'h0001;
	localparam logic [15:0] PCT_SEL_CMPEN = 16'h0002;
	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [31:0] PCT_RST_CMP = 32'h0000_0000;
	localparam logic [15:0] PCT_RST_DELAY = 16'h0000;
	localparam logic [31:0] PCT_RST_ROUTE = 32'h0000_0000;
	localparam logic [31:0] PCT_RST_EXP3 = 32'h0000_0000;
	localparam logic [15:0] PCT_RST_EXP2 = 16'h0000;
	localparam logic [15:0] PCT_RST_FLAGSEL = 16'h0000;
	localparam logic [15:0] PCT_RST_WIDTH = 16'h0001;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int PCT_CLK_MHZ = 50;
	localparam int PCT_WIDTH_STEP_NS = 100000; // 0.1 ms
	localparam int PCT_TICK_CYCLES = (PCT_WIDTH_STEP_NS * PCT_CLK_MHZ) / 1000;
	localparam int PCT_DELAY_STEP_NS = 100; // 0.1 us
	localparam int PCT_SAMPLE_PERIOD_NS = 62500; // position sample period
	localparam int PCT_SAMPLE_STEPS = PCT_SAMPLE_PERIOD_NS / PCT_DELAY_STEP_NS;
endpackage

/* src/pct_pulse_timer.sv */
`timescale 1ns/1ns
module pct_pulse_timer
	import pct_pkg::*;
#(
	parameter int TICK_CYCLES = PCT_TICK_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic start,
	input wire logic [15:0] width,
	output logic active
);
	typedef struct packed {
		logic [15:0] steps;
		logic [15:0] sub;
		logic active;
	} pct_timer_state_t;
	pct_timer_state_t q, d;

	// ************************************************************
	// pulse countdown in 0.1 ms steps
	// ************************************************************
	always_comb
	begin
		d = q;
		if (clear)
			d = '0;
		else if (start)
		begin
			d.steps = (width == 16'h0000) ? 16'h0001 : width;
			d.sub = 16'(TICK_CYCLES - 1);
			d.active = 1'b1;
		end
		else if (q.active)
		begin
			if (q.sub == 16'h0000)
			begin
				d.sub = 16'(TICK_CYCLES - 1);
				d.steps = q.steps - 16'h0001;
				d.active = q.steps != 16'h0001;
			end
			else
				d.sub = q.sub - 16'h0001;
		end
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end
	assign active = q.active;
endmodule

/* src/pct_top.sv */
// How it works
// - eight signed 32-bit compare values are checked against actual position
// - signed 16-bit delay compensation in 0.1 us steps shifts the compared position
// - comparator n uses nibble n-1 of the routing word, comparator 8 bits 31..28
// - nibble 0 suppresses, 1 2 3 select trigger terminal one two three
// - several comparators may share one terminal, each one pulses it
// - expansion-three bit 10 low enables the function, high disables it
// - with bit 15 low, bit 8 picks motion-in-progress or mains-off
// - bit 15 chooses between bit 8 and the flag select register
// - flag select 0 retract, 1 virtual loop or feedback, 2 compare enabled
// - crossing a value either way, seen as a relation change, starts a pulse
// - a crossing during a pulse keeps it on and restarts full width
// - resting exactly on a value gives one pulse only
// - pulse width is programmed in 0.1 ms steps from 0.1 to 6553.5 ms
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module pct_top
	import pct_pkg::*;
#(
	parameter int TICK_CYCLES = PCT_TICK_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] actual_position,
	input wire logic position_strobe,
	input wire logic motion_in_progress,
	input wire logic mains_off_flag,
	input wire logic retract_status,
	input wire logic virtual_loop_or_feedback_status,
	output logic trigger_terminal_one,
	output logic trigger_terminal_two,
	output logic trigger_terminal_three,
	output logic compare_function_enabled_status,
	output logic response_status_bit
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [PCT_N_CMP-1:0][31:0] cmp;
		logic [15:0] delay;
		logic [31:0] route;
		logic [31:0] exp3;
		logic [15:0] exp2;
		logic [15:0] flagsel;
		logic [15:0] width;
		logic [31:0] rdata;
		logic [31:0] pos_prev;
		logic pos_seen;
		logic [31:0] pos_comp;
		logic comp_strobe;
		logic status;
	} pct_top_state_t;
	pct_top_state_t q, d;

	logic cmp_en;
	logic mapped;
	logic access;
	logic [PCT_N_CMP-1:0] hit;
	logic [PCT_N_TERM-1:0] req;
	logic [PCT_N_TERM-1:0] active;

	// ************************************************************
	// bus decode
	// ************************************************************
	// zero-wait slave; unaligned or out-of-range words are errors
	assign access = psel && penable;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= PCT_OFF_STATE);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = q.rdata;

	assign cmp_en = !q.exp3[PCT_EXP3_DISABLE_BIT];
	assign compare_function_enabled_status = cmp_en;

	// ************************************************************
	// comparators
	// ************************************************************
	genvar gk;
	generate
		for (gk = 0; gk < PCT_N_CMP; gk++)
		begin : g_cmp
			pct_cross_det u_det (
				.clk(clk),
				.rst(rst),
				.sample(q.comp_strobe),
				.position(q.pos_comp),
				.value(q.cmp[gk]),
				.hit(hit[gk])
			);
		end
	endgenerate

	// ************************************************************
	// routing of hits to terminals
	// ************************************************************
	always_comb
	begin
		req = '0;
		for (int k = 0; k < PCT_N_CMP; k++)
		begin
			for (int t = 0; t < PCT_N_TERM; t++)
			begin
				if (hit[k] && (q.route[k*PCT_ROUTE_W +: PCT_ROUTE_W] == 4'(t + 1)))
					req[t] = 1'b1;
			end
		end
	end

	// ************************************************************
	// pulse timers
	// ************************************************************
	genvar gt;
	generate
		for (gt = 0; gt < PCT_N_TERM; gt++)
		begin : g_term
			pct_pulse_timer #(
				.TICK_CYCLES(TICK_CYCLES)
			) u_tmr (
				.clk(clk),
				.rst(rst),
				.clear(!cmp_en),
				.start(req[gt] && cmp_en),
				.width(q.width),
				.active(active[gt])
			);
		end
	endgenerate

	assign trigger_terminal_one = active[0];
	assign trigger_terminal_two = active[1];
	assign trigger_terminal_three = active[2];

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		logic signed [32:0] vel;
		logic signed [48:0] prod;
		logic signed [48:0] corr;
		vel = '0;
		prod = '0;
		corr = '0;
		d = q;
		d.comp_strobe = 1'b0;

		// register writes take effect at the access edge
		if (access && pwrite && mapped)
		begin
			case (paddr)
				PCT_OFF_DELAY: d.delay = pwdata[15:0];
				PCT_OFF_ROUTE: d.route = pwdata;
				PCT_OFF_EXP3: d.exp3 = pwdata;
				PCT_OFF_EXP2: d.exp2 = pwdata[15:0];
				PCT_OFF_FLAGSEL: d.flagsel = pwdata[15:0];
				PCT_OFF_WIDTH: d.width = pwdata[15:0];
				PCT_OFF_STATE: d.width = q.width; // read-only
				default: d.cmp[paddr[4:2]] = pwdata;
			endcase
		end

		// read data is captured in the setup cycle
		if (psel && !penable)
		begin
			d.rdata = '0;
			if (mapped)
			begin
				case (paddr)
					PCT_OFF_DELAY: d.rdata = {16'h0000, q.delay};
					PCT_OFF_ROUTE: d.rdata = q.route;
					PCT_OFF_EXP3: d.rdata = q.exp3;
					PCT_OFF_EXP2: d.rdata = {16'h0000, q.exp2};
					PCT_OFF_FLAGSEL: d.rdata = {16'h0000, q.flagsel};
					PCT_OFF_WIDTH: d.rdata = {16'h0000, q.width};
					PCT_OFF_STATE: d.rdata = {28'h0000000, active, cmp_en};
					default: d.rdata = q.cmp[paddr[4:2]];
				endcase
			end
		end

		if (position_strobe)
		begin
			if (q.pos_seen)
				vel = $signed({actual_position[31], actual_position}) - $signed({q.pos_prev[31], q.pos_prev});
			prod = vel * $signed(q.delay);
			corr = prod / PCT_SAMPLE_STEPS;
			d.pos_comp = actual_position + corr[31:0];
			d.pos_prev = actual_position;
			d.pos_seen = 1'b1;
			d.comp_strobe = 1'b1;
		end

		if (q.exp2[PCT_EXP2_EXPAND_BIT])
		begin
			case (q.flagsel)
				PCT_SEL_RETRACT: d.status = retract_status;
				PCT_SEL_VLOOP: d.status = virtual_loop_or_feedback_status;
				PCT_SEL_CMPEN: d.status = cmp_en;
				default: d.status = 1'b0;
			endcase
		end
		else
		begin
			d.status = q.exp2[PCT_EXP2_ACOFF_BIT] ? mains_off_flag : motion_in_progress;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.cmp <= {PCT_N_CMP{PCT_RST_CMP}};
			q.delay <= PCT_RST_DELAY;
			q.route <= PCT_RST_ROUTE;
			q.exp3 <= PCT_RST_EXP3;
			q.exp2 <= PCT_RST_EXP2;
			q.flagsel <= PCT_RST_FLAGSEL;
			q.width <= PCT_RST_WIDTH;
		end
		else
			q <= d;
	end
	assign response_status_bit = q.status;

	// ************************************************************
	// checks
	// ************************************************************
	property p_disable_quiet;
		@(posedge clk) disable iff (rst)
		!cmp_en |=> {trigger_terminal_one, trigger_terminal_two, trigger_terminal_three} == 3'h0;
	endproperty
	a_disable_quiet: assert property (p_disable_quiet) else $error("terminal active while disabled");

	property p_pulse_hold;
		@(posedge clk) disable iff (rst)
		req[0] && cmp_en ##1 cmp_en [*8] |-> trigger_terminal_one;
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("pulse ended early");

	property p_rose_cause;
		@(posedge clk) disable iff (rst)
		$rose(trigger_terminal_two) |-> $past(req[1]);
	endproperty
	a_rose_cause: assert property (p_rose_cause) else $error("pulse without routed hit");

	property p_nibble_eight;
		@(posedge clk) disable iff (rst)
		hit[7] && cmp_en && (q.route[31:28] == 4'h3) |=> trigger_terminal_three;
	endproperty
	a_nibble_eight: assert property (p_nibble_eight) else $error("comparator 8 misrouted");

	property p_shared;
		@(posedge clk) disable iff (rst)
		hit[1] && !hit[0] && cmp_en && (q.route[7:0] == 8'h11) |=> trigger_terminal_one;
	endproperty
	a_shared: assert property (p_shared) else $error("shared terminal missed pulse");

	property p_status_motion;
		@(posedge clk) disable iff (rst)
		!q.exp2[15] && !q.exp2[8] |=> response_status_bit == $past(motion_in_progress);
	endproperty
	a_status_motion: assert property (p_status_motion) else $error("status not motion");

	property p_status_sel;
		@(posedge clk) disable iff (rst)
		q.exp2[15] && (q.flagsel == 16'h0002) |=> response_status_bit == $past(cmp_en);
	endproperty
	a_status_sel: assert property (p_status_sel) else $error("status not compare enable");

	property p_unmapped;
		@(posedge clk) disable iff (rst)
		psel && penable && (paddr == 8'h3C) |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

	property p_route_write;
		@(posedge clk) disable iff (rst)
		access && pwrite && (paddr == PCT_OFF_ROUTE) |=> q.route == $past(pwdata);
	endproperty
	a_route_write: assert property (p_route_write) else $error("routing word not stored");

	property p_delay_store;
		@(posedge clk) disable iff (rst)
		access && pwrite && (paddr == PCT_OFF_DELAY) |=> q.delay == $past(pwdata[15:0]);
	endproperty
	a_delay_store: assert property (p_delay_store) else $error("delay amount not stored");

	property p_delay_zero;
		@(posedge clk) disable iff (rst)
		position_strobe && (q.delay == 16'h0000) |=> q.pos_comp == $past(actual_position);
	endproperty
	a_delay_zero: assert property (p_delay_zero) else $error("position shifted with zero delay");

	property p_suppress;
		@(posedge clk) disable iff (rst)
		q.route == 32'h0000_0000 |-> req == 3'h0;
	endproperty
	a_suppress: assert property (p_suppress) else $error("request with all outputs suppressed");

	property p_start_two;
		@(posedge clk) disable iff (rst)
		req[1] && cmp_en |=> trigger_terminal_two;
	endproperty
	a_start_two: assert property (p_start_two) else $error("crossing gave no pulse");

	property p_status_mains;
		@(posedge clk) disable iff (rst)
		!q.exp2[PCT_EXP2_EXPAND_BIT] && q.exp2[PCT_EXP2_ACOFF_BIT] |=> response_status_bit == $past(mains_off_flag);
	endproperty
	a_status_mains: assert property (p_status_mains) else $error("status not mains off");

	property p_status_retract;
		@(posedge clk) disable iff (rst)
		q.exp2[PCT_EXP2_EXPAND_BIT] && (q.flagsel == PCT_SEL_RETRACT) |=> response_status_bit == $past(retract_status);
	endproperty
	a_status_retract: assert property (p_status_retract) else $error("status not retract");

	property p_status_vloop;
		@(posedge clk) disable iff (rst)
		q.exp2[PCT_EXP2_EXPAND_BIT] && (q.flagsel == PCT_SEL_VLOOP) |=>
			response_status_bit == $past(virtual_loop_or_feedback_status);
	endproperty
	a_status_vloop: assert property (p_status_vloop) else $error("status not loop or feedback");
endmodule
